// ---- design/mfc_top.sv ----
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - samples enter through a four-entry 24-bit input queue, then fir modes store them in sample memory
// - result register loads only after all taps of the current sample are done
// - tap-count bits 11..0 hold taps minus one and drive address generation
// - 24-bit control and status register, bits 3..0 host writable, all readable
// - 24-bit arithmetic control register selects datapath modes
// - two 16-bit base pointers for sample and coefficient buffers
// - 24-bit register holds the channel count field
// - multichannel runs channel-length field plus one channels
// - multichannel select bit chooses multichannel, else single channel
// - each period one sample per channel, in channel order, repeating
// - shared-coefficient bit: one set for all, else one set per channel
// - fir: store input, multiply stored inputs by coefficients, sum to result
// - multichannel fir uses the previous sample instead of the current one
// - iir: sum outputs times coefficients plus input, result, then store it
// - iir input is scaled or not according to the input-scaling bit
// - both memory banks are 24 bits wide, samples x space, coefficients y space
// - circular buffers span count words inside consecutive power-of-two blocks
// - device writes samples into each buffer itself, from lower addresses up
module mfc_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // peripheral register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mfc_pkg::DW-1:0] reg_wdata,
  output logic [mfc_pkg::DW-1:0] reg_rdata,
  output logic reg_rvalid,
  // coefficient memory load port
  input wire logic coef_wr,
  input wire logic [mfc_pkg::AW-1:0] coef_addr,
  input wire logic [mfc_pkg::DW-1:0] coef_wdata
);

  // smallest k with 2^k at least m+1
  function automatic logic [3:0] blk_k(input logic [mfc_pkg::CW-1:0] m);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 0; i < mfc_pkg::CW; i++) begin
      if ((13'(1) << i) < (13'(m) + 13'h001)) begin
        k = 4'(i + 1);
      end
    end
    return k;
  endfunction

  // circular increment over 0..m
  function automatic logic [mfc_pkg::CW-1:0] wrap_inc(input logic [mfc_pkg::CW-1:0] x,
                                                     input logic [mfc_pkg::CW-1:0] m);
    return (x == m) ? 12'h000 : x + 12'h001;
  endfunction

  mfc_pkg::mfc_ctrl_t ctrl_q, ctrl_d;
  logic [mfc_pkg::DW-1:0] alu_q, alu_d, cnt_q, cnt_d, dch_q, dch_d, result_q, result_d;
  logic [15:0] dbase_q, dbase_d, cbase_q, cbase_d;
  logic rdy_q, rdy_d, rvalid_q, rvalid_d;
  logic [mfc_pkg::DW-1:0] rdata_q, rdata_d;
  logic [mfc_pkg::DW-1:0] fifo_q [mfc_pkg::FIFO_DEPTH];
  logic [1:0] wp_q, wp_d, rp_q, rp_d;
  logic [2:0] filter_tap_count_q, filter_tap_count_d;
  mfc_pkg::mfc_state_t st_q, st_d;
  logic [mfc_pkg::CHW-1:0] ch_q, ch_d, last_ch;
  logic [mfc_pkg::CW-1:0] tap_q, tap_d, idx_q, idx_d, m, newp;
  logic [mfc_pkg::CW-1:0] ptr_q [mfc_pkg::MAX_CH];
  logic [mfc_pkg::CW-1:0] ptr_d [mfc_pkg::MAX_CH];
  logic signed [mfc_pkg::ACCW-1:0] acc_q, acc_d, prod, scaled_in, res_sum;
  logic [mfc_pkg::DW-1:0] samp_q, samp_d, swdata;
  logic macd_q, macd_d, push, pop, swe, store_first, res_rd;
  logic [mfc_pkg::AW-1:0] doff, saddr, rd_saddr, rd_caddr;
  logic [3:0] k;
  logic [mfc_pkg::DW-1:0] smem [mfc_pkg::MEM_DEPTH];
  logic [mfc_pkg::DW-1:0] cmem [mfc_pkg::MEM_DEPTH];

  // address generation: per-channel block of 2^k words behind the sample base, and behind the coefficient base unless shared
  always_comb begin
    m = cnt_q[mfc_pkg::CW-1:0];
    k = blk_k(m);
    doff = mfc_pkg::AW'(16'(ch_q) << k);
    newp = wrap_inc(ptr_q[ch_q], m);
    saddr = dbase_q[mfc_pkg::AW-1:0] + doff + newp[mfc_pkg::AW-1:0];
    rd_saddr = dbase_q[mfc_pkg::AW-1:0] + doff + idx_q[mfc_pkg::AW-1:0];
    rd_caddr = cbase_q[mfc_pkg::AW-1:0] + (ctrl_q.sco ? 8'h00 : doff) + tap_q[mfc_pkg::AW-1:0];
    last_ch = ctrl_q.mlc ? dch_q[mfc_pkg::CHW-1:0] : 4'h0;
    store_first = !ctrl_q.filter_type_bit && !ctrl_q.mlc;
    prod = mfc_pkg::ACCW'($signed(smem[rd_saddr])) * mfc_pkg::ACCW'($signed(cmem[rd_caddr])); // full 48-bit product
    scaled_in = alu_q[mfc_pkg::ACR_ISL] ? mfc_pkg::ACCW'($signed(samp_q))
              : (mfc_pkg::ACCW'($signed(samp_q)) <<< alu_q[mfc_pkg::ACR_SCL_LSB +: 2]);
    res_sum = acc_q + (ctrl_q.filter_type_bit ? (scaled_in <<< mfc_pkg::FRAC) : 56'sh0);
  end

  // filter sequencer
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    tap_d = tap_q;
    idx_d = idx_q;
    acc_d = acc_q;
    samp_d = samp_q;
    macd_d = macd_q;
    result_d = result_q;
    ptr_d = ptr_q;
    pop = 1'b0;
    swe = 1'b0;
    swdata = (macd_q && ctrl_q.filter_type_bit) ? result_q : samp_q;
    case (st_q)
      mfc_pkg::ST_IDLE: begin
        if (ctrl_q.en && filter_tap_count_q != 3'h0) begin
          pop = 1'b1;
          samp_d = fifo_q[rp_q];
          acc_d = '0;
          tap_d = '0;
          macd_d = 1'b0;
          idx_d = wrap_inc(ptr_q[ch_q], m);
          st_d = store_first ? mfc_pkg::ST_WRITE : mfc_pkg::ST_MAC;
        end
      end
      mfc_pkg::ST_WRITE: begin
        swe = 1'b1;
        ptr_d[ch_q] = newp;
        if (!macd_q) begin
          idx_d = wrap_inc(newp, m);
          st_d = mfc_pkg::ST_MAC;
        end else begin
          ch_d = (ch_q == last_ch) ? 4'h0 : ch_q + 4'h1;
          st_d = mfc_pkg::ST_IDLE;
        end
      end
      mfc_pkg::ST_MAC: begin
        acc_d = acc_q + prod;
        tap_d = tap_q + 12'h001;
        idx_d = wrap_inc(idx_q, m);
        if (tap_q == m) begin
          st_d = mfc_pkg::ST_FINISH;
        end
      end
      mfc_pkg::ST_FINISH: begin
        result_d = res_sum[mfc_pkg::FRAC +: mfc_pkg::DW];
        macd_d = 1'b1;
        if (store_first) begin
          ch_d = (ch_q == last_ch) ? 4'h0 : ch_q + 4'h1;
          st_d = mfc_pkg::ST_IDLE;
        end else begin
          st_d = mfc_pkg::ST_WRITE;
        end
      end
      default: begin
        st_d = mfc_pkg::ST_IDLE;
      end
    endcase
    if (!ctrl_q.en) begin
      st_d = mfc_pkg::ST_IDLE;
      ch_d = 4'h0;
      swe = 1'b0;
    end
  end

  // host registers, input queue and read port
  always_comb begin
    ctrl_d = ctrl_q;
    alu_d = alu_q;
    cnt_d = cnt_q;
    dch_d = dch_q;
    dbase_d = dbase_q;
    cbase_d = cbase_q;
    push = reg_wr && reg_addr == mfc_pkg::REG_SAMPLE_IN && filter_tap_count_q != mfc_pkg::FIFO_FULL;
    res_rd = reg_rd && reg_addr == mfc_pkg::REG_RESULT;
    wp_d = wp_q + (push ? 2'h1 : 2'h0);
    rp_d = rp_q + (pop ? 2'h1 : 2'h0);
    filter_tap_count_d = filter_tap_count_q + (push ? 3'h1 : 3'h0) - (pop ? 3'h1 : 3'h0);
    rdy_d = (st_q == mfc_pkg::ST_FINISH) || (rdy_q && !res_rd); // set wins over read clear
    if (reg_wr) begin
      case (reg_addr)
        mfc_pkg::REG_CTRL: ctrl_d = reg_wdata[3:0];
        mfc_pkg::REG_ALU: alu_d = reg_wdata;
        mfc_pkg::REG_TAP_COUNT: cnt_d = reg_wdata;
        mfc_pkg::REG_DBASE: dbase_d = reg_wdata[15:0];
        mfc_pkg::REG_CBASE: cbase_d = reg_wdata[15:0];
        mfc_pkg::REG_DCH: dch_d = reg_wdata;
        default: ;
      endcase
    end
    rvalid_d = reg_rd;
    rdata_d = mfc_pkg::RST_WORD;
    if (reg_rd) begin
      case (reg_addr)
        mfc_pkg::REG_RESULT: rdata_d = result_q;
        mfc_pkg::REG_TAP_COUNT: rdata_d = cnt_q;
        mfc_pkg::REG_CTRL: begin
          rdata_d[3:0] = ctrl_q;
          rdata_d[mfc_pkg::CS_BUSY] = st_q != mfc_pkg::ST_IDLE;
          rdata_d[mfc_pkg::CS_IN_FULL] = filter_tap_count_q == mfc_pkg::FIFO_FULL;
          rdata_d[mfc_pkg::CS_IN_EMPTY] = filter_tap_count_q == 3'h0;
          rdata_d[mfc_pkg::CS_RES_READY] = rdy_q;
        end
        mfc_pkg::REG_ALU: rdata_d = alu_q;
        mfc_pkg::REG_DBASE: rdata_d = {8'h00, dbase_q};
        mfc_pkg::REG_CBASE: rdata_d = {8'h00, cbase_q};
        mfc_pkg::REG_DCH: rdata_d = dch_q;
        default: rdata_d = mfc_pkg::RST_WORD;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= mfc_pkg::RST_CTRL;
      alu_q <= mfc_pkg::RST_WORD;
      cnt_q <= mfc_pkg::RST_WORD;
      dch_q <= mfc_pkg::RST_WORD;
      dbase_q <= mfc_pkg::RST_BASE;
      cbase_q <= mfc_pkg::RST_BASE;
      result_q <= mfc_pkg::RST_WORD;
      rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= mfc_pkg::RST_WORD;
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      filter_tap_count_q <= 3'h0;
      st_q <= mfc_pkg::ST_IDLE;
      ch_q <= 4'h0;
      tap_q <= 12'h000;
      idx_q <= 12'h000;
      acc_q <= 56'sh0;
      samp_q <= mfc_pkg::RST_WORD;
      macd_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      alu_q <= alu_d;
      cnt_q <= cnt_d;
      dch_q <= dch_d;
      dbase_q <= dbase_d;
      cbase_q <= cbase_d;
      result_q <= result_d;
      rdy_q <= rdy_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      filter_tap_count_q <= filter_tap_count_d;
      st_q <= st_d;
      ch_q <= ch_d;
      tap_q <= tap_d;
      idx_q <= idx_d;
      acc_q <= acc_d;
      samp_q <= samp_d;
      macd_q <= macd_d;
    end
  end

  // per-channel newest-sample pointers
  for (genvar g = 0; g < mfc_pkg::MAX_CH; g++) begin : g_ptr
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ptr_q[g] <= 12'h000;
      end else begin
        ptr_q[g] <= ptr_d[g];
      end
    end
  end

  // queue storage and the two 24-bit memory banks
  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifo_q[wp_q] <= reg_wdata;
    end
    if (swe) begin
      smem[saddr] <= swdata;
    end
    if (coef_wr) begin
      cmem[coef_addr] <= coef_wdata;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_store_then_mac;
    st_q == mfc_pkg::ST_WRITE ##1 st_q == mfc_pkg::ST_MAC;
  endsequence
  sequence s_write_then_idle;
    st_q == mfc_pkg::ST_WRITE ##1 st_q == mfc_pkg::ST_IDLE;
  endsequence

  property p_fifo_bound;
    (filter_tap_count_q == mfc_pkg::FIFO_FULL && reg_wr && reg_addr == mfc_pkg::REG_SAMPLE_IN && !pop)
      |=> filter_tap_count_q == mfc_pkg::FIFO_FULL && $stable(wp_q);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("input queue accepted a word while full");
  property p_result_cause;
    $changed(result_q) |-> $past(st_q) == mfc_pkg::ST_FINISH;
  endproperty
  a_result_cause: assert property (p_result_cause) else $error("result changed outside finish");
  property p_ready_set_wins;
    (st_q == mfc_pkg::ST_FINISH && res_rd) |=> rdy_q;
  endproperty
  a_ready_set_wins: assert property (p_ready_set_wins) else $error("result ready lost on read");
  // tap count checked, not the sum: unwritten sample words are unknown in early passes
  property p_tap_len;
    (st_q == mfc_pkg::ST_MAC && tap_q == m && ctrl_q.en)
      |=> st_q == mfc_pkg::ST_FINISH && tap_q == m + 12'h001;
  endproperty
  a_tap_len: assert property (p_tap_len) else $error("mac did not end after last tap");
  property p_chan_range;
    ch_q <= last_ch || !$stable(ctrl_q);
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel index past channel count");
  property p_chan_order;
    ($changed(ch_q) && ctrl_q.en && $past(ctrl_q.en)) |->
      ch_q == (($past(ch_q) == last_ch) ? 4'h0 : $past(ch_q) + 4'h1);
  endproperty
  a_chan_order: assert property (p_chan_order) else $error("channel sequence out of order");
  property p_fir_single;
    (pop && store_first) |=> s_store_then_mac;
  endproperty
  a_fir_single: assert property (p_fir_single) else $error("single fir did not store before mac");
  property p_iir_tail;
    (st_q == mfc_pkg::ST_FINISH && ctrl_q.filter_type_bit && ctrl_q.en) ##1 ctrl_q.en |-> s_write_then_idle and swdata == result_q;
  endproperty
  a_iir_tail: assert property (p_iir_tail) else $error("iir output not stored after result");
  property p_no_mem_when_off;
    !ctrl_q.en |-> !swe && !pop;
  endproperty
  a_no_mem_when_off: assert property (p_no_mem_when_off) else $error("memory touched while disabled");
endmodule
`default_nettype wire

// ---- design/mfc_pkg.sv ----
package mfc_pkg;
  // data path and memory geometry
  localparam int DW = 24;
  localparam int AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam int CW = 12;
  localparam int CHW = 4;
  localparam int MAX_CH = 16;
  localparam int ACCW = 56;
  localparam int FRAC = 23;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL = 3'h4;

  // register indices on the peripheral register port
  localparam logic [3:0] REG_SAMPLE_IN = 4'h0;
  localparam logic [3:0] REG_RESULT = 4'h1;
  localparam logic [3:0] REG_CONSTANT = 4'h2;
  localparam logic [3:0] REG_TAP_COUNT = 4'h3;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_ALU = 4'h5;
  localparam logic [3:0] REG_DBASE = 4'h6;
  localparam logic [3:0] REG_CBASE = 4'h7;
  localparam logic [3:0] REG_DCH = 4'h8;

  // control and status, and arithmetic control field positions
  localparam int CS_BUSY = 16;
  localparam int CS_IN_FULL = 20;
  localparam int CS_IN_EMPTY = 21;
  localparam int CS_RES_READY = 22;
  localparam int ACR_ISL = 0;
  localparam int ACR_SCL_LSB = 1;

  // reset values
  localparam logic [DW-1:0] RST_WORD = 24'h000000;
  localparam logic [15:0] RST_BASE = 16'h0000;

  typedef struct packed {
    logic sco;
    logic mlc;
    logic filter_type_bit;
    logic en;
  } mfc_ctrl_t;

  localparam mfc_ctrl_t RST_CTRL = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_MAC,
    ST_FINISH
  } mfc_state_t;
endpackage

// ---- tb/mfc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// host core side: one register or coefficient access at a time
module mfc_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic reg_rvalid,
  // coefficient load port
  output logic coef_wr,
  output logic [7:0] coef_addr,
  output logic [23:0] coef_wdata
);
  // idle bus at time zero
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata, coef_wr, coef_addr, coef_wdata} = '0;
  end

  // write: held over one edge, data scrambled once released
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    #2 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #2 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // read: answer taken in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [23:0] d, output logic v);
    @(posedge clk_sys);
    #2 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #2 reg_rd = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask

  // coefficient word load, reversed order kept by the caller
  task automatic cwr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_sys);
    #2 coef_addr = a;
    coef_wdata = d;
    coef_wr = 1'b1;
    @(posedge clk_sys);
    #2 coef_wr = 1'b0;
    coef_wdata = ~d;
  endtask
endmodule

`default_nettype wire

// ---- tb/test_multichannel_filter_coprocessor.sv ----
`timescale 1ns/10ps
`default_nettype none

module test_multichannel_filter_coprocessor;
  localparam int M = 2; // three taps, block of four words
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid, coef_wr, vv;
  logic [3:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, coef_wdata, rv;
  logic [7:0] coef_addr;
  logic [31:0] rnd;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  longint coef [8];
  longint hist [2][3];
  logic [3:0] ra [9] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h4, 4'h2, 4'hf, 4'h1};
  logic [23:0] wd [9] = '{24'h5a5002, 24'h123456, 24'hfff0f0, 24'h12a5a4, 24'h876541, 24'hfffff8,
                          24'h111111, 24'h222222, 24'h333333};
  logic [23:0] ex [9] = '{24'h5a5002, 24'h123456, 24'h00f0f0, 24'h00a5a4, 24'h876541, 24'h200008,
                          24'h0, 24'h0, 24'h0};

  mfc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .coef_wr(coef_wr), .coef_addr(coef_addr), .coef_wdata(coef_wdata));
  mfc_host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .coef_wr(coef_wr),
    .coef_addr(coef_addr), .coef_wdata(coef_wdata));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic longint sx(input logic [23:0] v);
    return longint'(signed'(v));
  endfunction

  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // read a register, check the answer and its valid flag
  task automatic rdchk(input logic [3:0] a, input logic [23:0] e);
    host_u.rd(a, rv, vv);
    chk("rvalid", {23'h0, vv}, 24'h1);
    chk("register", rv, e);
  endtask

  task automatic do_reset();
    #2 rst_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    #2 rst_n = 1'b1;
  endtask

  // history model: index 0 oldest, paired with the lowest coefficient
  task automatic push(input int c, input longint v);
    hist[c][0] = hist[c][1];
    hist[c][1] = hist[c][2];
    hist[c][2] = v;
  endtask

  // one filter session of ten periods, edge periods feed zeros
  task automatic session(input logic [3:0] ctrl, input logic [2:0] acr, input int nch);
    longint acc, x;
    int off;
    logic [23:0] res;
    hist = '{default: 0};
    host_u.wr(mfc_pkg::REG_ALU, {21'h0, acr});
    host_u.wr(mfc_pkg::REG_DCH, 24'(nch - 1));
    host_u.wr(mfc_pkg::REG_CTRL, {20'h0, ctrl});
    host_u.wr(mfc_pkg::REG_CTRL, {20'h0, ctrl | 4'h1});
    for (int p = 0; p < 10; p++) begin
      for (int c = 0; c < nch; c++) begin
        rnd = lfsr(rnd);
        x = (p < 3 || p > 6) ? 0 : sx({{2{rnd[21]}}, rnd[21:0]});
        off = ctrl[3] ? 0 : c * 4;
        host_u.wr(mfc_pkg::REG_SAMPLE_IN, 24'(x));
        // single fir: the third read lands in the finishing cycle, ready must survive it
        if (ctrl[2:1] == 2'b00) begin
          host_u.rd(mfc_pkg::REG_CTRL, rv, vv);
          host_u.rd(mfc_pkg::REG_CTRL, rv, vv);
          host_u.rd(mfc_pkg::REG_RESULT, rv, vv);
        end
        if (!ctrl[1] && !ctrl[2]) push(c, x);
        acc = 0;
        for (int j = 0; j <= M; j++) acc += coef[off + j] * hist[c][j];
        if (ctrl[1]) acc += (x <<< (acr[0] ? 0 : acr[2:1])) <<< 23;
        res = 24'(acc >>> 23);
        if (ctrl[1]) push(c, sx(res));
        else if (ctrl[2]) push(c, x);
        rv = '0;
        for (int w = 0; w < 40 && rv[22] !== 1'b1; w++) host_u.rd(mfc_pkg::REG_CTRL, rv, vv);
        chk("ready", {23'h0, rv[22]}, 24'h1);
        host_u.rd(mfc_pkg::REG_RESULT, rv, vv);
        if (p >= 3) chk("result", rv, res);
      end
    end
    host_u.wr(mfc_pkg::REG_CTRL, 24'h0);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    rnd = 32'h38375bdb;
    do_reset();
    rdchk(mfc_pkg::REG_CTRL, 24'h200000);
    for (int i = 0; i < 9; i++) begin
      host_u.wr(ra[i], wd[i]);
      rdchk(ra[i], ex[i]);
    end
    host_u.wr(mfc_pkg::REG_CTRL, 24'h0);
    for (int i = 0; i < 5; i++) host_u.wr(mfc_pkg::REG_SAMPLE_IN, 24'(i + 1));
    rdchk(mfc_pkg::REG_CTRL, 24'h100000);
    do_reset();
    rdchk(mfc_pkg::REG_CTRL, 24'h200000);
    rdchk(mfc_pkg::REG_TAP_COUNT, 24'h0);
    host_u.wr(mfc_pkg::REG_TAP_COUNT, 24'(M));
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      coef[i] = sx(rnd[23:0]);
      host_u.cwr(8'(i), rnd[23:0]);
    end
    session(4'h0, 3'h0, 1);
    session(4'h2, 3'h2, 1);
    session(4'h4, 3'h0, 2);
    session(4'he, 3'h1, 2);
    conclude();
  end
endmodule

`default_nettype wire
